//--- core/ccpc_pkg.sv
// What this block does
// - Doubler bit enables multiplier; reserved seven bits.
// - Low-power mode is bits six and three.
// - Mode 01 sleeps to idle, 10 to standby.
// - Mode 11 standby exits after 64 cycles.
// - Wakeup bit clear ignores bus request.
// - Wakeup bit set lets bus request exit idle or standby.
package ccpc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    // Only the low six address bits are decoded; the top two are don't-care.
    localparam int IO_DECODE_BITS = 6;
    localparam logic [5:0] CLOCK_DOUBLER_CONTROL_ADDR = 6'h1e;
    localparam logic [5:0] PROCESSOR_CLOCK_POWER_CONTROL_ADDR = 6'h1f;

    // Clock doubler control fields and read-back value of reserved bits.
    localparam int DOUBLER_ENABLE_BIT = 7;
    localparam logic DOUBLER_ENABLE_RESET = 1'b0;
    localparam logic [6:0] DOUBLER_RESERVED_READ = 7'h7f;

    // Processor clock and power control fields.
    localparam int CLOCK_DIVIDE_BIT = 7;
    localparam int MODE_HIGH_BIT = 6;
    localparam int BUS_REQUEST_WAKEUP_BIT = 5;
    localparam int REDUCED_DRIVE_CLOCK_OUT_BIT = 4;
    localparam int MODE_LOW_BIT = 3;
    localparam int REDUCED_DRIVE_IO_BIT = 2;
    localparam int REDUCED_DRIVE_CONTROL_PINS_BIT = 1;
    localparam int REDUCED_DRIVE_BUS_PINS_BIT = 0;
    localparam logic [7:0] PROCESSOR_CLOCK_POWER_CONTROL_RESET = 8'h00;

    // Value returned for an unmapped address.
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ----------------------------------------------------------------
    // Low-power modes and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_IDLE = 2'h1;
    localparam logic [1:0] MODE_STANDBY = 2'h2;
    localparam logic [1:0] MODE_STANDBY_QUICK = 2'h3;

    localparam int TIMER_WIDTH = 16;
    localparam logic [15:0] QUICK_RECOVERY_CYCLES = 16'h0040;
    localparam logic [15:0] TIMER_ONE = 16'h0001;
    localparam logic [15:0] TIMER_ZERO = 16'h0000;

    // One-hot power states.
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_SLEEP = 5'h02,
        ST_IDLE = 5'h04,
        ST_STANDBY = 5'h08,
        ST_RECOVER = 5'h10
    } ccpc_state_e;

endpackage : ccpc_pkg

//--- core/ccpc_top.sv
`timescale 1ns/1ps
module ccpc_top #(
    // Cycles of ordinary standby recovery; shorten it in simulation.
    parameter logic [15:0] NORMAL_RECOVERY_CYCLES = 16'h1000
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Internal I/O register port
    input wire logic [7:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    output logic io_hit_out,
    // Core events
    input wire logic sleep_in,
    input wire logic wake_event_in,
    input wire logic external_bus_request_in,
    // Clock control
    output logic clock_doubling_enable_out,
    output logic system_clock_undivided_out,
    // Drive strength control
    output logic reduced_drive_clock_out_out,
    output logic reduced_drive_io_out,
    output logic reduced_drive_control_pins_out,
    output logic reduced_drive_bus_pins_out,
    // Power state
    output logic [1:0] low_power_mode_out,
    output logic cpu_run_out,
    output logic sleeping_out,
    output logic idle_out,
    output logic standby_out,
    output logic recovering_out
);

    // ----------------------------------------------------------------
    // Register storage and decode
    // ----------------------------------------------------------------
    logic doubler_enable;
    logic [7:0] power_control;
    logic [5:0] reg_addr;
    logic sel_doubler;
    logic sel_power;
    logic [7:0] next_rdata;
    logic [1:0] mode_sel;
    logic external_bus_request_exit;
    logic exit_request;
    logic quick_standby;
    ccpc_pkg::ccpc_state_e state;
    ccpc_pkg::ccpc_state_e next_state;
    logic timer_load;
    logic [15:0] timer_value;
    logic [15:0] timer_count;
    logic timer_done;

    // The upper address bits are ignored so the block answers on every mirror.
    assign reg_addr = io_addr_in[ccpc_pkg::IO_DECODE_BITS-1:0];
    assign sel_doubler = (reg_addr == ccpc_pkg::CLOCK_DOUBLER_CONTROL_ADDR);
    assign sel_power = (reg_addr == ccpc_pkg::PROCESSOR_CLOCK_POWER_CONTROL_ADDR);
    assign io_hit_out = sel_doubler | sel_power;

    // Only the doubler bit is stored; reserved bits keep no state.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            doubler_enable <= ccpc_pkg::DOUBLER_ENABLE_RESET;
        end else if (io_wr_in && sel_doubler) begin
            doubler_enable <= io_wdata_in[ccpc_pkg::DOUBLER_ENABLE_BIT];
        end
    end

    // All eight control bits are plain read/write storage.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            power_control <= ccpc_pkg::PROCESSOR_CLOCK_POWER_CONTROL_RESET;
        end else if (io_wr_in && sel_power) begin
            power_control <= io_wdata_in;
        end
    end

    // Read mux; reserved doubler bits read back as ones.
    always_comb begin
        next_rdata = ccpc_pkg::UNMAPPED_READ;
        if (sel_doubler) begin
            next_rdata = {doubler_enable, ccpc_pkg::DOUBLER_RESERVED_READ};
        end else if (sel_power) begin
            next_rdata = power_control;
        end
    end

    // Read data is registered so it is stable for the whole cycle after the strobe.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            io_rdata_out <= ccpc_pkg::UNMAPPED_READ;
        end else if (io_rd_in) begin
            io_rdata_out <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Control outputs
    // ----------------------------------------------------------------
    // Outputs come straight from register bits, so a write shows one cycle later.
    assign clock_doubling_enable_out = doubler_enable;
    assign system_clock_undivided_out = power_control[ccpc_pkg::CLOCK_DIVIDE_BIT];
    assign reduced_drive_clock_out_out = power_control[ccpc_pkg::REDUCED_DRIVE_CLOCK_OUT_BIT];
    assign reduced_drive_io_out = power_control[ccpc_pkg::REDUCED_DRIVE_IO_BIT];
    assign reduced_drive_control_pins_out = power_control[ccpc_pkg::REDUCED_DRIVE_CONTROL_PINS_BIT];
    assign reduced_drive_bus_pins_out = power_control[ccpc_pkg::REDUCED_DRIVE_BUS_PINS_BIT];

    // The mode is split over two bits that are not neighbours.
    assign mode_sel = {power_control[ccpc_pkg::MODE_HIGH_BIT], power_control[ccpc_pkg::MODE_LOW_BIT]};
    assign low_power_mode_out = mode_sel;

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    // A bus request only counts as a wake source when software allows it.
    assign external_bus_request_exit = external_bus_request_in && power_control[ccpc_pkg::BUS_REQUEST_WAKEUP_BIT];
    assign exit_request = wake_event_in || external_bus_request_exit;

    always_comb begin
        next_state = state;
        case (state)
            ccpc_pkg::ST_RUN: begin
                if (sleep_in) begin
                    case (mode_sel)
                        ccpc_pkg::MODE_IDLE: next_state = ccpc_pkg::ST_IDLE;
                        ccpc_pkg::MODE_STANDBY: next_state = ccpc_pkg::ST_STANDBY;
                        ccpc_pkg::MODE_STANDBY_QUICK: next_state = ccpc_pkg::ST_STANDBY;
                        default: next_state = ccpc_pkg::ST_SLEEP;
                    endcase
                end
            end
            ccpc_pkg::ST_SLEEP: begin
                if (wake_event_in) begin
                    next_state = ccpc_pkg::ST_RUN;
                end
            end
            ccpc_pkg::ST_IDLE: begin
                if (exit_request) begin
                    next_state = ccpc_pkg::ST_RUN;
                end
            end
            ccpc_pkg::ST_STANDBY: begin
                if (exit_request) begin
                    next_state = ccpc_pkg::ST_RECOVER;
                end
            end
            ccpc_pkg::ST_RECOVER: begin
                if (timer_done) begin
                    next_state = ccpc_pkg::ST_RUN;
                end
            end
            default: next_state = ccpc_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ccpc_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // The recovery kind is latched at sleep, so a later register write cannot alter it.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            quick_standby <= 1'b0;
        end else if (state == ccpc_pkg::ST_RUN && sleep_in) begin
            quick_standby <= (mode_sel == ccpc_pkg::MODE_STANDBY_QUICK);
        end
    end

    // State flags are decodes of one-hot flip-flops, so they are glitch free.
    assign cpu_run_out = (state == ccpc_pkg::ST_RUN);
    assign sleeping_out = (state == ccpc_pkg::ST_SLEEP);
    assign idle_out = (state == ccpc_pkg::ST_IDLE);
    assign standby_out = (state == ccpc_pkg::ST_STANDBY);
    assign recovering_out = (state == ccpc_pkg::ST_RECOVER);

    // ----------------------------------------------------------------
    // Recovery timer
    // ----------------------------------------------------------------
    // Loaded one short, so the recover state lasts exactly the full count.
    assign timer_load = (state == ccpc_pkg::ST_STANDBY) && exit_request;
    assign timer_value = quick_standby ? (ccpc_pkg::QUICK_RECOVERY_CYCLES - ccpc_pkg::TIMER_ONE)
                                       : (NORMAL_RECOVERY_CYCLES - ccpc_pkg::TIMER_ONE);

    ccpc_wake_timer u_wake_timer (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .load_in(timer_load),
        .load_value_in(timer_value),
        .count_out(timer_count),
        .done_out(timer_done)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence quick_exit_s;
        standby_out && exit_request && quick_standby;
    endsequence

    sequence quick_recover_s;
        recovering_out ##63 recovering_out ##1 cpu_run_out;
    endsequence

    doubler_write_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        io_wr_in && sel_doubler |=> clock_doubling_enable_out == $past(io_wdata_in[ccpc_pkg::DOUBLER_ENABLE_BIT])
    ) else $error("doubler enable does not follow write");

    mode_none_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        cpu_run_out && sleep_in && mode_sel == ccpc_pkg::MODE_NONE |=> sleeping_out && !idle_out && !standby_out
    ) else $error("mode 00 entered idle or standby");

    idle_entry_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        cpu_run_out && sleep_in && low_power_mode_out == ccpc_pkg::MODE_IDLE |=> idle_out
    ) else $error("mode 01 sleep did not enter idle");

    standby_entry_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        cpu_run_out && sleep_in && (mode_sel == ccpc_pkg::MODE_STANDBY || mode_sel == ccpc_pkg::MODE_STANDBY_QUICK)
        |=> standby_out
    ) else $error("standby mode sleep did not enter standby");

    quick_exit_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        quick_exit_s |=> quick_recover_s
    ) else $error("quick recovery not 64 cycles");

    external_bus_request_ignore_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (idle_out || standby_out) && external_bus_request_in
        && !power_control[ccpc_pkg::BUS_REQUEST_WAKEUP_BIT] && !wake_event_in
        |=> $stable(state)
    ) else $error("bus request woke device while disabled");

    external_bus_request_exit_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (idle_out || standby_out) && external_bus_request_in && power_control[ccpc_pkg::BUS_REQUEST_WAKEUP_BIT]
        |=> !idle_out && !standby_out
    ) else $error("bus request did not end idle or standby");

    clock_divide_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        io_wr_in && sel_power |=> system_clock_undivided_out == $past(io_wdata_in[ccpc_pkg::CLOCK_DIVIDE_BIT])
    ) else $error("clock divide select does not follow write");

endmodule : ccpc_top

//--- core/ccpc_wake_timer.sv
`timescale 1ns/1ps
module ccpc_wake_timer (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Load request
    input wire logic load_in,
    input wire logic [15:0] load_value_in,
    // Status
    output logic [15:0] count_out,
    output logic done_out
);

    // ----------------------------------------------------------------
    // Down counter
    // ----------------------------------------------------------------
    // Counts down to zero and stays there; a load always wins over counting.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_out <= ccpc_pkg::TIMER_ZERO;
        end else if (load_in) begin
            count_out <= load_value_in;
        end else if (count_out != ccpc_pkg::TIMER_ZERO) begin
            count_out <= count_out - ccpc_pkg::TIMER_ONE;
        end
    end

    // Done is a plain decode so the state machine can leave on the last count.
    assign done_out = (count_out == ccpc_pkg::TIMER_ZERO);

endmodule : ccpc_wake_timer

//--- sim/test_cpu_clock_power_mode_control.sv
`timescale 1ns/1ps
module test_cpu_clock_power_mode_control;

    // ----------------------------------------------------------------
    // Signals and counters
    // ----------------------------------------------------------------
    // Ordinary recovery is shortened so the run stays brief.
    localparam logic [15:0] NORMAL_CYCLES = 16'h0010;
    // Selectors for the event inputs that the pulse task drives.
    localparam int PULSE_SLEEP = 0;
    localparam int PULSE_WAKE = 1;
    localparam int PULSE_BUS = 2;
    logic ref_clk_in, rst_in, io_wr_in, io_rd_in, io_hit_out, sleep_in, wake_event_in, external_bus_request_in;
    logic [7:0] io_addr_in, io_wdata_in, io_rdata_out;
    logic clock_doubling_enable_out, system_clock_undivided_out, reduced_drive_clock_out_out;
    logic reduced_drive_io_out, reduced_drive_control_pins_out, reduced_drive_bus_pins_out;
    logic [1:0] low_power_mode_out;
    logic cpu_run_out, sleeping_out, idle_out, standby_out, recovering_out;
    int failures, total_checks, cycles;

    ccpc_top #(.NORMAL_RECOVERY_CYCLES(NORMAL_CYCLES)) dut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in),
        .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .io_hit_out(io_hit_out),
        .sleep_in(sleep_in), .wake_event_in(wake_event_in), .external_bus_request_in(external_bus_request_in),
        .clock_doubling_enable_out(clock_doubling_enable_out),
        .system_clock_undivided_out(system_clock_undivided_out),
        .reduced_drive_clock_out_out(reduced_drive_clock_out_out), .reduced_drive_io_out(reduced_drive_io_out),
        .reduced_drive_control_pins_out(reduced_drive_control_pins_out),
        .reduced_drive_bus_pins_out(reduced_drive_bus_pins_out), .low_power_mode_out(low_power_mode_out),
        .cpu_run_out(cpu_run_out), .sleeping_out(sleeping_out), .idle_out(idle_out),
        .standby_out(standby_out), .recovering_out(recovering_out));

    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    // The core clock runs at 20 MHz.
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    // A hang in any wait loop is cut short here and reported as a mismatch.
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            close_out();
        end
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Strobes are raised and dropped at falling edges, so each is seen at exactly one rising edge.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk_in);
        io_addr_in = addr;
        io_wdata_in = data;
        io_wr_in = 1'b1;
        @(negedge ref_clk_in);
        io_wr_in = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge ref_clk_in);
        io_addr_in = addr;
        io_rd_in = 1'b1;
        @(negedge ref_clk_in);
        io_rd_in = 1'b0;
        check("read data", {8'h00, exp}, {8'h00, io_rdata_out});
    endtask : rd

    // Drives the chosen event input directly, since a copied argument would never reach the pin.
    task automatic set_event(input int which, input logic level);
        case (which)
            PULSE_SLEEP: sleep_in = level;
            PULSE_WAKE: wake_event_in = level;
            default: external_bus_request_in = level;
        endcase
    endtask : set_event

    task automatic pulse(input int which);
        @(negedge ref_clk_in);
        set_event(which, 1'b1);
        @(negedge ref_clk_in);
        set_event(which, 1'b0);
    endtask : pulse

    function automatic logic [15:0] flags();
        return {11'h000, cpu_run_out, sleeping_out, idle_out, standby_out, recovering_out};
    endfunction : flags

    // Counts the falling edges at which recovery is shown, then expects the run state.
    task automatic recover(input int exp);
        int n;
        n = 0;
        while (recovering_out === 1'b1 && n < 5000) begin
            n = n + 1;
            @(negedge ref_clk_in);
        end
        check("recovery cycles", exp[15:0], n[15:0]);
        check("run after recovery", 16'h0010, flags());
    endtask : recover

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        check("run at reset", 16'h0010, flags());
        rd(8'h1e, 8'h7f);
        rd(8'h1f, 8'h00);
        check("divider at reset", 16'h0000, {15'h0000, system_clock_undivided_out});
    endtask : test_reset

    task automatic test_doubler();
        wr(8'h1e, 8'hff);
        check("doubler on", 16'h0001, {15'h0000, clock_doubling_enable_out});
        rd(8'h1e, 8'hff);
        wr(8'h1e, 8'h00);
        check("doubler off", 16'h0000, {15'h0000, clock_doubling_enable_out});
        rd(8'h1e, 8'h7f);
    endtask : test_doubler

    task automatic test_fields();
        wr(8'h1f, 8'h97);
        check("undivided", 16'h0001, {15'h0000, system_clock_undivided_out});
        check("drive bits", 16'h000f, {12'h000, reduced_drive_clock_out_out, reduced_drive_io_out,
            reduced_drive_control_pins_out, reduced_drive_bus_pins_out});
        check("mode none", 16'h0000, {14'h0000, low_power_mode_out});
        rd(8'h1f, 8'h97);
        wr(8'hdf, 8'h48);
        check("mode alias", 16'h0003, {14'h0000, low_power_mode_out});
        check("mirror hit", 16'h0001, {15'h0000, io_hit_out});
        check("divided", 16'h0000, {15'h0000, system_clock_undivided_out});
        check("drive bits off", 16'h0000, {12'h000, reduced_drive_clock_out_out, reduced_drive_io_out,
            reduced_drive_control_pins_out, reduced_drive_bus_pins_out});
        wr(8'h20, 8'hff);
        check("unmapped hit", 16'h0000, {15'h0000, io_hit_out});
        rd(8'h20, 8'h00);
        rd(8'h1f, 8'h48);
    endtask : test_fields

    // Each mode with wakeup disabled: bus request is refused, then the wake event exits.
    task automatic test_modes();
        logic [15:0] want;
        for (int m = 0; m < 4; m++) begin
            wr(8'h1f, {1'b0, m[1], 2'b00, m[0], 3'b000});
            check("mode field", m[15:0], {14'h0000, low_power_mode_out});
            pulse(PULSE_SLEEP);
            want = (m == 0) ? 16'h0008 : (m == 1) ? 16'h0004 : 16'h0002;
            check("sleep state", want, flags());
            external_bus_request_in = 1'b1;
            repeat (4) @(negedge ref_clk_in);
            check("request ignored", want, flags());
            external_bus_request_in = 1'b0;
            pulse(PULSE_WAKE);
            if (m >= 2) begin
                recover((m == 3) ? 64 : int'(NORMAL_CYCLES));
            end else begin
                check("wake to run", 16'h0010, flags());
            end
        end
    endtask : test_modes

    // Wakeup enabled: bus request exits idle and standby but never plain sleep.
    task automatic test_bus_wake();
        wr(8'h1f, 8'h28);
        pulse(PULSE_SLEEP);
        pulse(PULSE_BUS);
        check("idle bus exit", 16'h0010, flags());
        wr(8'h1f, 8'h60);
        pulse(PULSE_SLEEP);
        pulse(PULSE_BUS);
        check("standby bus exit", 16'h0001, flags());
        recover(int'(NORMAL_CYCLES));
        wr(8'h1f, 8'h20);
        pulse(PULSE_SLEEP);
        pulse(PULSE_BUS);
        check("sleep keeps", 16'h0008, flags());
        pulse(PULSE_SLEEP);
        check("sleep ignored", 16'h0008, flags());
        pulse(PULSE_WAKE);
        check("sleep wake", 16'h0010, flags());
    endtask : test_bus_wake

    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        failures = 0;
        total_checks = 0;
        cycles = 0;
        rst_in = 1'b1;
        io_addr_in = 8'h00;
        io_wdata_in = 8'h00;
        io_wr_in = 1'b0;
        io_rd_in = 1'b0;
        sleep_in = 1'b0;
        wake_event_in = 1'b0;
        external_bus_request_in = 1'b0;
        repeat (8) @(negedge ref_clk_in);
        rst_in = 1'b0;
        test_reset();
        test_doubler();
        test_fields();
        test_modes();
        test_bus_wake();
        close_out();
    end

endmodule : test_cpu_clock_power_mode_control
